// *** hw/irq_gate.sv ***
`timescale 1ns/1ns
`include "uart_irq_consts.svh"
// ==========================================================
// Enable gating and priority identification
module irq_gate (
  // Sources, enables and results
  irq_gate_if.gate gif
);
  import uart_irq_pkg::*;
  logic g_rxav; // Gated receive data
  logic g_rxto; // Gated time-out
  logic g_txe; // Gated transmit empty
  logic g_lerr; // Gated line status
  logic g_modem; // Gated modem change
  logic g_abdone; // Gated auto-baud done
  logic g_abto; // Gated auto-baud timeout
  // Priority encode: line status first, modem last
  function automatic logic [2:0] id_code(input logic lerr,
    input logic rxav, input logic rxto, input logic txe);
    if (lerr) begin
      id_code = `ID_LERR; // RQ14
    end else if (rxav) begin
      id_code = `ID_RXAV;
    end else if (rxto) begin
      id_code = `ID_RXTO;
    end else if (txe) begin
      id_code = `ID_TXE;
    end else begin
      id_code = `ID_MODEM;
    end
  endfunction : id_code
  // One enable bit masks both receive data and time-out
  assign g_rxav = gif.rxav & gif.en[`EN_RXAV_BIT]; // RQ2
  assign g_rxto = gif.rxto & gif.en[`EN_RXAV_BIT]; // RQ2
  assign g_txe = gif.txe & gif.en[`EN_TXE_BIT]; // RQ3
  assign g_lerr = gif.lerr & gif.en[`EN_LERR_BIT]; // RQ4
  assign g_modem = gif.modem & gif.en[`EN_MODEM_BIT]; // RQ5
  assign g_abdone = gif.abdone & gif.en[`EN_ABDONE_BIT]; // RQ9
  assign g_abto = gif.abto & gif.en[`EN_ABTO_BIT]; // RQ10
  // Any enabled pending source raises the request
  assign gif.irq = g_rxav | g_rxto | g_txe | g_lerr | g_modem | g_abdone |
    g_abto; // RQ16
  assign gif.id = {id_code(g_lerr, g_rxav, g_rxto, g_txe), ~gif.irq};
endmodule : irq_gate

// *** hw/irq_gate_if.sv ***
`timescale 1ns/1ns
// ==========================================================
// Pending sources and enables towards the gating logic
interface irq_gate_if;
  import uart_irq_pkg::*;
  irq_en_type en; // Enable register image
  logic rxav; // Receive data available
  logic rxto; // Character time-out
  logic txe; // Transmit holding empty
  logic lerr; // Receive line status error
  logic modem; // Modem status change
  logic abdone; // Auto-baud finished
  logic abto; // Auto-baud timed out
  logic irq; // Combined gated request
  logic [3:0] id; // Identification, bit 0 low when pending
  modport gate (input en, rxav, rxto, txe, lerr, modem, abdone, abto,
    output irq, id);
  modport core (output en, rxav, rxto, txe, lerr, modem, abdone, abto,
    input irq, id);
endinterface : irq_gate_if

// *** hw/pin_sync3.sv ***
`timescale 1ns/1ns
// ==========================================================
// Three-stage pin synchroniser with change detection
module pin_sync3 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pin side
  input wire logic pin_in,
  // Core side
  output logic level,
  output logic changed
);
  logic s1_ff; // Metastable stage, read only by s2_ff
  logic s2_ff;
  logic s3_ff;
  wire agree = (s2_ff == s3_ff);
  // Shift the pin through three stages
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // Accept a new level only once two late stages agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b1;
      changed <= 1'b0;
    end else begin
      changed <= agree && (s3_ff != level);
      if (agree) begin
        level <= s3_ff;
      end
    end
  end
endmodule : pin_sync3

// *** hw/uart_irq_consts.svh ***
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH
// ==========================================================
// Register map (byte addresses)
`define IRQ_EN_ADDR 32'hE001_0004
`define IRQ_ID_ADDR 32'hE001_0008
// ==========================================================
// Enable register fields
`define EN_RXAV_BIT 0
`define EN_TXE_BIT 1
`define EN_LERR_BIT 2
`define EN_MODEM_BIT 3
`define EN_CTS_BIT 7
`define EN_ABDONE_BIT 8
`define EN_ABTO_BIT 9
`define EN_RESET 10'h000
`define EN_WR_MASK 10'h38F
// ==========================================================
// Identification codes
`define ID_LERR 3'h3
`define ID_RXAV 3'h2
`define ID_RXTO 3'h6
`define ID_TXE 3'h1
`define ID_MODEM 3'h0
// ==========================================================
// Character time in 16x baud ticks (start, 8 data, stop)
`define CHAR_TICKS 160
`define CTI_CHARS 4
`endif

// *** hw/uart_irq_enable.sv ***
`timescale 1ns/1ns
`include "uart_irq_consts.svh"
// ==========================================================
// Notes on behaviour
// [RQ1] Enable register decoded only with divisor access clear
// [RQ2] Bit 0 gates data available and time-out
// [RQ3] Bit 1 gates transmit empty; status stays visible
// [RQ4] Bit 2 gates line status errors
// [RQ5] Bit 3 gates modem status changes
// [RQ6] Software writes zeros to reserved bits
// [RQ7] Auto flow: clear-to-send change needs bits 3, 7
// [RQ8] Manual flow: clear-to-send change needs bit 3
// [RQ9] Bit 8 gates auto-baud done
// [RQ10] Bit 9 gates auto-baud timeout
// [RQ11] Zero masks, one permits; all reset zero
// [RQ12] Data available while fill at trigger level
// [RQ13] Time-out after about four idle characters
// [RQ14] Line status reports code 011, top priority
// [RQ15] Auto-baud flags read true only when enabled
// [RQ16] Request is OR of enabled sources, every cycle
module uart_irq_enable
  import uart_irq_pkg::*;
#(
  parameter int FILL_W = 5,
  parameter int CHAR_TICKS = `CHAR_TICKS,
  parameter int CTI_CHARS = `CTI_CHARS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Line control
  input wire logic divisor_latch_access_bit,
  input wire logic auto_cts_en,
  // Receive FIFO view
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [FILL_W-1:0] rx_trigger,
  input wire logic rx_fifo_activity,
  input wire logic baud16_tick,
  // Other sources
  input wire logic tx_holding_empty,
  input wire logic [3:0] rx_line_status,
  input wire logic [2:0] modem_delta_other,
  input wire logic modem_status_read,
  input wire logic clear_to_send_input,
  input wire logic autobaud_done_evt,
  input wire logic autobaud_timeout_evt,
  input wire logic [1:0] autobaud_clear,
  // Results
  output logic uart_irq,
  output logic [3:0] irq_id,
  output logic autobaud_done_flag,
  output logic autobaud_timeout_flag,
  output logic tx_holding_empty_status
);
  // ==========================================================
  // Declarations
  localparam int CTI_TICKS = CHAR_TICKS * CTI_CHARS;
  localparam int CNT_W = $clog2(CTI_TICKS + 1);
  localparam logic [CNT_W-1:0] CTI_LAST = CNT_W'(CTI_TICKS - 1);
  bus_state_type state_ff; // Bus slave phase
  irq_en_type en_ff; // Enable register
  logic rxav_ff; // Fill at or above trigger
  logic rxto_ff; // Character time-out pending
  logic [CNT_W-1:0] idle_cnt_ff; // Idle ticks since FIFO activity
  logic cts_flag_ff; // Latched clear-to-send change
  logic abdone_ff; // Sticky auto-baud done event
  logic abto_ff; // Sticky auto-baud timeout event
  logic cts_chg; // One-cycle change pulse
  irq_gate_if gif ();
  // ==========================================================
  // Address decode
  wire req = avs_read | avs_write;
  wire hit_en = (avs_address == `IRQ_EN_ADDR) &&
    !divisor_latch_access_bit; // RQ1
  wire hit_id = (avs_address == `IRQ_ID_ADDR);
  wire ack = (state_ff == BUS_ANSWER);
  wire wr_en = ack && avs_write && hit_en;
  // Byte lanes: bits 7:0 in lane 0, bits 9:8 in lane 1
  wire [9:0] lane_mask = {{2{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [9:0] wr_bits = lane_mask & `EN_WR_MASK;
  // Reserved bits are not stored; they read back as zero
  wire [9:0] nxt_en = (en_ff & ~wr_bits) |
    (avs_writedata[9:0] & wr_bits); // RQ6
  wire [31:0] en_word = {22'h000000, en_ff};
  wire [31:0] id_word = {22'h000000, autobaud_timeout_flag,
    autobaud_done_flag, 4'h0, irq_id};
  wire [31:0] nxt_rdata = hit_en ? en_word : (hit_id ? id_word :
    32'h00000000);
  // ==========================================================
  // Avalon slave: one wait cycle, then the answer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      case (state_ff)
        BUS_IDLE: begin
          // Latch read data now so it stands at the accept edge
          if (req) begin
            state_ff <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? nxt_rdata : 32'h00000000;
          end
        end
        default: begin
          state_ff <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
  // Enable register, all sources masked after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= `EN_RESET; // RQ11
    end else if (wr_en) begin
      en_ff <= nxt_en; // RQ11
    end
  end
  // ==========================================================
  // Receive data available follows the fill level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxav_ff <= 1'b0;
    end else begin
      rxav_ff <= (rx_fill >= rx_trigger); // RQ12
    end
  end
  // Idle counter; a tick of jitter keeps it in the allowed span
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_ff <= '0;
      rxto_ff <= 1'b0;
    end else if (rx_fifo_activity || (rx_fill == '0)) begin
      // Activity or empty FIFO restarts the wait
      idle_cnt_ff <= '0;
      rxto_ff <= 1'b0;
    end else if (baud16_tick && !rxto_ff) begin
      // Counting stops once raised, so the count cannot wrap
      if (idle_cnt_ff == CTI_LAST) begin
        rxto_ff <= 1'b1; // RQ13
      end
      idle_cnt_ff <= idle_cnt_ff + CNT_W'(1);
    end
  end
  // ==========================================================
  // Clear-to-send pin
  pin_sync3 u_cts_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(clear_to_send_input),
    .level(),
    .changed(cts_chg)
  );
  // In auto mode a change counts only with its own enable
  wire cts_allow = en_ff[`EN_MODEM_BIT] &
    (!auto_cts_en | en_ff[`EN_CTS_BIT]); // RQ7 RQ8
  // Latch the change; a new change beats a status read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_flag_ff <= 1'b0;
    end else if (cts_chg && cts_allow) begin
      cts_flag_ff <= 1'b1; // RQ7 RQ8
    end else if (modem_status_read) begin
      cts_flag_ff <= 1'b0;
    end
  end
  // Sticky auto-baud events, set wins over clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      abdone_ff <= 1'b0;
      abto_ff <= 1'b0;
    end else begin
      abdone_ff <= autobaud_done_evt | (abdone_ff & ~autobaud_clear[0]);
      abto_ff <= autobaud_timeout_evt | (abto_ff & ~autobaud_clear[1]);
    end
  end
  // ==========================================================
  // Gating and identification
  assign gif.en = en_ff;
  assign gif.rxav = rxav_ff;
  assign gif.rxto = rxto_ff;
  assign gif.txe = tx_holding_empty;
  assign gif.lerr = |rx_line_status;
  assign gif.modem = cts_flag_ff | (|modem_delta_other);
  assign gif.abdone = abdone_ff;
  assign gif.abto = abto_ff;
  irq_gate u_gate (
    .gif(gif)
  );
  // Register every result; transmit empty status is shown unmasked
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_irq <= 1'b0;
      irq_id <= 4'h1;
      autobaud_done_flag <= 1'b0;
      autobaud_timeout_flag <= 1'b0;
      tx_holding_empty_status <= 1'b0;
    end else begin
      uart_irq <= gif.irq; // RQ16
      irq_id <= gif.id; // RQ14
      autobaud_done_flag <= abdone_ff & en_ff[`EN_ABDONE_BIT]; // RQ15
      autobaud_timeout_flag <= abto_ff & en_ff[`EN_ABTO_BIT]; // RQ15
      tx_holding_empty_status <= tx_holding_empty; // RQ3
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Writes must bounce off while the divisor latch is selected
  AST_DIVLATCH_BLOCKS: assert property ( // RQ1
    (ack && avs_write && divisor_latch_access_bit) |=> $stable(en_ff))
    else $error("enable written while divisor access set");
  // Bit 0 low with no other source leaves the request quiet
  AST_RXAV_MASK: assert property ( // RQ2
    (!en_ff[`EN_RXAV_BIT] && !gif.txe && !gif.lerr && !gif.modem &&
     !gif.abdone && !gif.abto) |=> !uart_irq)
    else $error("receive sources not masked by bit 0");
  // The time-out code only ever shows with bit 0 set
  AST_RXTO_MASK: assert property ( // RQ2
    (irq_id == {`ID_RXTO, 1'b0}) |-> $past(en_ff[`EN_RXAV_BIT]))
    else $error("time-out reported while masked");
  // A masked transmit empty still shows in the status copy
  AST_TXE_SEEN: assert property ( // RQ3
    (gif.txe && !en_ff[`EN_TXE_BIT]) |=> tx_holding_empty_status)
    else $error("transmit empty status hidden by mask");
  // Transmit empty alone with bit 1 low raises nothing
  AST_TXE_MASK: assert property ( // RQ3
    (gif.txe && !en_ff[`EN_TXE_BIT] && !gif.rxav && !gif.rxto &&
     !gif.lerr && !gif.modem && !gif.abdone && !gif.abto) |=> !uart_irq)
    else $error("transmit empty not masked by bit 1");
  // Line status code needs bit 2 one cycle earlier
  AST_LERR_MASK: assert property ( // RQ4
    (irq_id == {`ID_LERR, 1'b0}) |-> $past(en_ff[`EN_LERR_BIT]))
    else $error("line status reported while masked");
  // Code 000 is shared with auto-baud, which has no code of its own
  AST_MODEM_MASK: assert property ( // RQ5
    (uart_irq && irq_id[3:1] == `ID_MODEM) |->
    $past((gif.modem && en_ff[`EN_MODEM_BIT]) ||
      (gif.abdone && en_ff[`EN_ABDONE_BIT]) ||
      (gif.abto && en_ff[`EN_ABTO_BIT])))
    else $error("modem reported while masked");
  // Auto flow control: a change without bit 7 is dropped
  AST_CTS_AUTO: assert property ( // RQ7
    (cts_chg && auto_cts_en && !en_ff[7] && !cts_flag_ff) |=>
    !cts_flag_ff)
    else $error("auto flow change latched without bit 7");
  // Manual flow control: bit 3 alone lets a change through
  AST_CTS_MANUAL: assert property ( // RQ8
    (cts_chg && !auto_cts_en && en_ff[3]) |=> cts_flag_ff)
    else $error("manual flow change lost");
  // Auto-baud flags show only the enabled sticky events
  AST_ABDONE_GATE: assert property ( // RQ9
    autobaud_done_flag |-> $past(en_ff[`EN_ABDONE_BIT] && abdone_ff))
    else $error("auto-baud done shown while masked");
  AST_ABTO_GATE: assert property ( // RQ10
    autobaud_timeout_flag |-> $past(en_ff[`EN_ABTO_BIT] && abto_ff))
    else $error("auto-baud timeout shown while masked");
  // A full zero write masks every source again
  AST_EN_WRITE: assert property ( // RQ11
    (wr_en && avs_byteenable[1:0] == 2'h3 && avs_writedata[9:0] == 10'h000)
    |=> (en_ff == 10'h000))
    else $error("zero write left a source enabled");
  // Fill held at the trigger level must show as data available
  AST_RXAV_LEVEL: assert property ( // RQ12
    (rx_fill >= rx_trigger) [*2] |-> rxav_ff)
    else $error("data available missing at trigger level");
  // The time-out rises only at the end of the idle count
  AST_RXTO_IDLE: assert property ( // RQ13
    $rose(rxto_ff) |-> (rx_fill != '0) && ($past(idle_cnt_ff) == CTI_LAST))
    else $error("time-out raised early");
  // Line status beats every other pending source
  AST_LERR_FIRST: assert property ( // RQ14
    (gif.lerr && en_ff[`EN_LERR_BIT]) |=> (irq_id == 4'h6))
    else $error("line status not top priority");
  // An enabled data-available source shows on the request line
  AST_IRQ_OR: assert property ( // RQ16
    $past(rxav_ff && en_ff[0]) |-> uart_irq)
    else $error("enabled source gave no request");
  // The slave inserts exactly one wait state
  AST_BUS_ONE_WAIT: assert property (
    ($rose(req) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer later than one cycle");
  // Main scenarios worth seeing at least once
  COV_EN_WRITE: cover property (wr_en);
  COV_IRQ_RISE: cover property ($rose(uart_irq));
  COV_RXTO_RISE: cover property ($rose(rxto_ff));
  COV_CTS_AUTO: cover property (cts_chg && auto_cts_en && cts_allow);
  COV_AB_DONE: cover property ($rose(autobaud_done_flag));
endmodule : uart_irq_enable

// *** hw/uart_irq_pkg.sv ***
package uart_irq_pkg;
  // ==========================================================
  // Bus slave states
  typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_state_type;
  // Enable register image
  typedef logic [9:0] irq_en_type;
endpackage : uart_irq_pkg

// *** tb/cts_modem.sv ***
`timescale 1ns/1ns
// ==========================================================
// Far-end modem: owns the clear-to-send pin
module cts_modem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bench command, one pulse per transition
  input wire logic flip,
  // Line side
  output logic cts_pin
);
  // Pin resets high and holds its last level between flip pulses
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_pin <= 1'b1;
    end else if (flip) begin
      cts_pin <= ~cts_pin;
    end
  end
endmodule : cts_modem

// *** tb/tb_uart_irq_enable.sv ***
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the interrupt-enable block
module tb_uart_irq_enable;
  import uart_irq_pkg::*;
  localparam logic [31:0] EN_A = 32'hE001_0004; // Enable register
  localparam logic [31:0] EBIT [4] = '{32'h1, 32'h2, 32'h4, 32'h8};
  localparam logic [3:0] CODE [4] = '{4'h4, 4'h2, 4'h6, 4'h0};
  // Bench-driven inputs
  logic core_clk, rst_b, rd, wr, div_latch, auto_cts, act, tick, txe;
  logic msr_rd, flip;
  logic [31:0] addr, wdata, rdata;
  logic [4:0] fill, trig;
  logic [3:0] lsr;
  logic [2:0] mdo;
  logic [1:0] ab_evt, ab_clr;
  // Design outputs
  logic [31:0] avs_rdata;
  logic wait_req, irq, ab_done, ab_to, txe_st, cts;
  logic [3:0] id;
  int num_errors, samples_checked;
  // Short character time keeps the time-out at 16 ticks
  uart_irq_enable #(.FILL_W(5), .CHAR_TICKS(4), .CTI_CHARS(4)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(avs_rdata), .avs_waitrequest(wait_req),
    .divisor_latch_access_bit(div_latch), .auto_cts_en(auto_cts),
    .rx_fill(fill), .rx_trigger(trig), .rx_fifo_activity(act),
    .baud16_tick(tick), .tx_holding_empty(txe),
    .rx_line_status(lsr), .modem_delta_other(mdo),
    .modem_status_read(msr_rd), .clear_to_send_input(cts),
    .autobaud_done_evt(ab_evt[0]), .autobaud_timeout_evt(ab_evt[1]),
    .autobaud_clear(ab_clr), .uart_irq(irq), .irq_id(id),
    .autobaud_done_flag(ab_done), .autobaud_timeout_flag(ab_to),
    .tx_holding_empty_status(txe_st));
  cts_modem u_modem (.core_clk(core_clk), .rst_b(rst_b), .flip(flip),
    .cts_pin(cts));
  // ==========================================================
  // Clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    final_report();
  end
  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Compare, count, report a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do @(posedge core_clk); while (wait_req !== 1'b0);
    rdata = avs_rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // Raise or drop one level source by index
  task automatic set_src(input int k, input logic v);
    case (k)
      0: fill <= {3'h0, v, 1'b0};
      1: txe <= v;
      2: lsr <= {v, 3'h0};
      default: mdo <= {2'h0, v};
    endcase
  endtask : set_src
  // Verdict and end of run
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // ==========================================================
  // Test sequence
  initial begin
    {rst_b, rd, wr, div_latch, auto_cts, act, tick, txe, msr_rd, flip} = '0;
    {addr, wdata, rdata, fill, lsr, mdo, ab_evt, ab_clr} = '0;
    trig = 5'h02;
    cyc(6);
    rst_b <= 1'b1;
    // Reset state: everything masked, nothing pending
    bus(1'b0, EN_A, 32'h0);
    chk(rdata, 32'h0);
    chk({27'h0, irq, id}, 32'h1);
    // Software keeps reserved bits zero; they read back zero too
    bus(1'b1, EN_A, 32'h0000_038F);
    bus(1'b0, EN_A, 32'h0);
    chk(rdata, 32'h38F);
    // Divisor access hides the register; unmapped reads zero
    div_latch <= 1'b1;
    bus(1'b1, EN_A, 32'h0);
    bus(1'b0, EN_A, 32'h0);
    chk(rdata, 32'h0);
    div_latch <= 1'b0;
    bus(1'b0, EN_A, 32'h0);
    chk(rdata, 32'h38F);
    bus(1'b0, 32'hE001_0010, 32'h0);
    chk(rdata, 32'h0);
    // Each source: all other enables on stays masked, own bit passes
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, EN_A, 32'h38F & ~EBIT[k]);
      set_src(k, 1'b1);
      cyc(4);
      chk({31'h0, irq}, 32'h0);
      if (k == 1) chk({31'h0, txe_st}, 32'h1);
      bus(1'b1, EN_A, EBIT[k]);
      cyc(4);
      chk({irq, id}, {1'b1, CODE[k]});
      set_src(k, 1'b0);
    end
    // Line status outranks transmit empty
    bus(1'b1, EN_A, 32'h6);
    txe <= 1'b1;
    lsr <= 4'h2;
    cyc(4);
    chk({28'h0, id}, 32'h6);
    // The same code reads back through the identification register
    bus(1'b0, 32'hE001_0008, 32'h0);
    chk(rdata, 32'h6);
    txe <= 1'b0;
    lsr <= 4'h0;
    // Auto-baud events: sticky, visible only once enabled
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, EN_A, 32'h0);
      ab_evt <= 2'b01 << j;
      cyc(1);
      ab_evt <= 2'b00;
      cyc(3);
      chk({29'h0, irq, ab_to, ab_done}, 32'h0);
      bus(1'b1, EN_A, 32'h100 << j);
      cyc(2);
      chk({irq, ab_to, ab_done}, {1'b1, 2'b01 << j});
      ab_clr <= 2'b11;
      cyc(1);
      ab_clr <= 2'b00;
    end
    // Clear-to-send: auto mode needs bit 7 too, manual mode does not
    for (int c = 0; c < 3; c++) begin
      auto_cts <= (c < 2);
      bus(1'b1, EN_A, (c == 1) ? 32'h88 : 32'h8);
      flip <= 1'b1;
      cyc(1);
      flip <= 1'b0;
      cyc(8);
      chk({31'h0, irq}, {31'h0, c != 0});
      msr_rd <= 1'b1;
      cyc(1);
      msr_rd <= 1'b0;
      cyc(2);
      chk({31'h0, irq}, 32'h0);
    end
    // Time-out below trigger: 16 idle ticks, cleared by activity
    bus(1'b1, EN_A, 32'h1);
    trig <= 5'h04;
    fill <= 5'h01;
    tick <= 1'b1;
    cyc(12);
    chk({31'h0, irq}, 32'h0);
    cyc(12);
    chk({27'h0, irq, id}, 32'h1C);
    act <= 1'b1;
    cyc(1);
    act <= 1'b0;
    cyc(4);
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule : tb_uart_irq_enable
